//--- src/spf_consts.svh
`ifndef SPF_CONSTS_SVH
`define SPF_CONSTS_SVH
// Configuration port addresses
`define SPF_NUM_BIAS   5'h12
`define SPF_CA_CLAMP   5'h12
`define SPF_CA_MODE    5'h13
`define SPF_CA_HDR0    5'h14
`define SPF_CA_HDR1    5'h15
`define SPF_CA_TRL0    5'h16
`define SPF_CA_TRL1    5'h17
`define SPF_CA_OUTCFG  5'h18
// Field positions
`define SPF_RESTART_BIT 7
`define SPF_ANATST_BIT  6
`define SPF_OC_RATE     0
`define SPF_OC_DUAL     1
// Timing
`define SPF_FRAME_NS   185600
`define SPF_CLK_MHZ    40
`define SPF_MARK_FAST  4'h8
`define SPF_MARK_SLOW  4'h4
// Capture capacity in words per frame, per mode
`define SPF_CAP_M80    12'h396
`define SPF_CAP_D80    12'h72c
`define SPF_CAP_M160   12'h734
`define SPF_CAP_D160   12'he74
`define SPF_BANK_AW    12
// Slot of the first data word
`define SPF_DUAL_DATA  12'h003
`define SPF_SNGL_DATA  12'h006
`define SPF_LAST_BIT   4'hf
// Controller APB offsets
`define SPF_A_CTRL     8'h00
`define SPF_A_CFG      8'h04
`define SPF_A_RESTART  8'h08
`define SPF_A_STATUS   8'h0c
`define SPF_A_HDR      8'h10
`define SPF_A_CNT      8'h14
`define SPF_A_LEN      8'h18
`define SPF_A_FRAMES   8'h1c
`endif

//--- src/spf_pkg.sv
`include "spf_consts.svh"
package spf_pkg;
   typedef enum logic [1:0] {C_IDLE, C_SET, C_CLR} spf_cfg_state_type;

   typedef struct packed {
      logic [15:0]      timer;
      logic             running;
      logic             start_q;
      logic             acq_bank;
      logic [11:0]      acq_cnt;
      logic [11:0]      tx_cnt;
      logic [31:0]      frame_cnt;
      logic [31:0]      cnt_snap;
      logic             tx_on;
      logic [11:0]      slot;
      logic [3:0]       bit_idx;
      logic             div;
      logic             bclk;
      logic [3:0]       mark_cnt;
      logic             marker;
      logic             line0;
      logic             line1;
      logic [17:0][7:0] bias;
      logic [3:0]       clamp;
      logic [7:0]       mode;
      logic [15:0]      hdr0;
      logic [15:0]      hdr1;
      logic [15:0]      trl0;
      logic [15:0]      trl1;
      logic [1:0]       outcfg;
   } spf_dev_state_type;

   typedef struct packed {
      logic [31:0]       prdata;
      logic              pready;
      logic              pslverr;
      logic              start;
      logic [1:0]        outcfg;
      logic [7:0]        mode;
      spf_cfg_state_type cst;
      logic              cfg_we;
      logic [4:0]        cfg_addr;
      logic [15:0]       cfg_data;
      logic [3:0]        s1;
      logic [3:0]        s2;
      logic              clk_q;
      logic              mk_q;
      logic              rx_on;
      logic [2:0]        word;
      logic [3:0]        bit_idx;
      logic [15:0]       sr0;
      logic [15:0]       sr1;
      logic [31:0]       hdr;
      logic [31:0]       cnt;
      logic [15:0]       len0;
      logic [31:0]       len;
      logic [31:0]       frames;
   } spf_ctl_state_type;
endpackage : spf_pkg

//--- src/spf_link_if.sv
`timescale 1ns/1ps
interface spf_link_if;
   logic        cfg_we;
   logic [4:0]  cfg_addr;
   logic [15:0] cfg_data;
   logic        start;
   logic        bit_clk;
   logic        serial_line_zero;
   logic        serial_line_one;
   logic        marker;

   modport dev (
      input  cfg_we, cfg_addr, cfg_data, start,
      output bit_clk, serial_line_zero, serial_line_one, marker
   );
   modport ctl (
      output cfg_we, cfg_addr, cfg_data, start,
      input  bit_clk, serial_line_zero, serial_line_one, marker
   );
endinterface : spf_link_if

//--- src/spf_dev.sv
`timescale 1ns/1ps
`include "spf_consts.svh"
module spf_dev #(
   parameter int FRAME_CYCLES = (`SPF_FRAME_NS * `SPF_CLK_MHZ) / 1000
) (
   // Clock and reset
   input  wire logic         CLK_SYS,
   input  wire logic         RESET_N,
   // Link to controller and receiver
   spf_link_if.dev           LINK,
   // Hit words of the frame being acquired
   input  wire logic         HIT_VALID,
   input  wire logic [15:0]  HIT_WORD,
   // Analog settings
   output logic      [143:0] BIAS_CODES,
   output logic      [3:0]   CLAMP_CODE,
   output logic              ANA_TEST_EN
);
   localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYCLES - 1);

   spf_pkg::spf_dev_state_type st_reg;
   spf_pkg::spf_dev_state_type st_next;

   logic [15:0] mem [0:(2**(`SPF_BANK_AW+1))-1];
   logic        wr;

   logic        fast;
   logic        dual;
   logic        fall;
   logic        bound;
   logic [11:0] cap;
   logic [11:0] half;
   logic [11:0] last_slot;
   logic [11:0] d_idx;
   logic [11:0] rd_lo;
   logic [11:0] rd_hi;
   logic [15:0] w0;
   logic [15:0] w1;
   logic [15:0] m_lo;
   logic [15:0] m_hi;

   always_comb begin
      st_next = st_reg;
      fast = st_reg.outcfg[`SPF_OC_RATE];
      dual = st_reg.outcfg[`SPF_OC_DUAL];
      // Capture limit depends on the mode
      if (fast) begin
         cap = dual ? `SPF_CAP_D160 : `SPF_CAP_M160;
      end else begin
         cap = dual ? `SPF_CAP_D80 : `SPF_CAP_M80;
      end
      // Words per half, odd count padded up
      half = (st_reg.tx_cnt + 12'h001) >> 1;
      if (dual) begin
         last_slot = `SPF_DUAL_DATA + half;
         d_idx     = st_reg.slot - `SPF_DUAL_DATA;
         rd_lo     = {d_idx[10:0], 1'b0};
         rd_hi     = {d_idx[10:0], 1'b1};
      end else begin
         last_slot = `SPF_SNGL_DATA + {half[10:0], 1'b0} + 12'h001;
         d_idx     = st_reg.slot - `SPF_SNGL_DATA;
         rd_lo     = d_idx;
         rd_hi     = d_idx;
      end
      // Read the bank acquired during the previous frame
      m_lo = (rd_lo < st_reg.tx_cnt) ? mem[{~st_reg.acq_bank, rd_lo}]
                                     : 16'h0000;
      m_hi = (rd_hi < st_reg.tx_cnt) ? mem[{~st_reg.acq_bank, rd_hi}]
                                     : 16'h0000;
      // Word of the current slot on each line
      w0 = 16'h0000;
      w1 = 16'h0000;
      if (dual) begin
         if (st_reg.slot == 12'h000) begin
            w0 = st_reg.hdr0;
            w1 = st_reg.hdr1;
         end else if (st_reg.slot == 12'h001) begin
            w0 = st_reg.cnt_snap[15:0];
            w1 = st_reg.cnt_snap[31:16];
         end else if (st_reg.slot == 12'h002) begin
            w0 = {4'h0, half};
            w1 = {4'h0, half};
         end else if (st_reg.slot == last_slot) begin
            w0 = st_reg.trl0;
            w1 = st_reg.trl1;
         end else begin
            w0 = m_lo;
            w1 = m_hi;
         end
      end else begin
         if (st_reg.slot == 12'h000) begin
            w1 = st_reg.hdr0;
         end else if (st_reg.slot == 12'h001) begin
            w1 = st_reg.hdr1;
         end else if (st_reg.slot == 12'h002) begin
            w1 = st_reg.cnt_snap[15:0];
         end else if (st_reg.slot == 12'h003) begin
            w1 = st_reg.cnt_snap[31:16];
         end else if (st_reg.slot < `SPF_SNGL_DATA) begin
            w1 = {4'h0, half};
         end else if (st_reg.slot == last_slot - 12'h001) begin
            w1 = st_reg.trl0;
         end else if (st_reg.slot == last_slot) begin
            w1 = st_reg.trl1;
         end else begin
            w1 = m_lo;
         end
      end

      // Configuration port
      if (LINK.cfg_we) begin
         if (LINK.cfg_addr < `SPF_NUM_BIAS) begin
            st_next.bias[LINK.cfg_addr] = LINK.cfg_data[7:0];
         end else begin
            case (LINK.cfg_addr)
               `SPF_CA_CLAMP:  st_next.clamp  = LINK.cfg_data[3:0];
               `SPF_CA_MODE:   st_next.mode   = LINK.cfg_data[7:0];
               `SPF_CA_HDR0:   st_next.hdr0   = LINK.cfg_data;
               `SPF_CA_HDR1:   st_next.hdr1   = LINK.cfg_data;
               `SPF_CA_TRL0:   st_next.trl0   = LINK.cfg_data;
               `SPF_CA_TRL1:   st_next.trl1   = LINK.cfg_data;
               `SPF_CA_OUTCFG: st_next.outcfg = LINK.cfg_data[1:0];
               default: ;
            endcase
         end
      end

      // Acquisition into the current bank, truncated at the mode limit
      wr = st_reg.running && HIT_VALID && (st_reg.acq_cnt < cap);
      if (wr) begin
         st_next.acq_cnt = st_reg.acq_cnt + 12'h001;
      end

      // Free running bit clock, data changes on its falling edge
      fall = 1'b0;
      if (fast || st_reg.div) begin
         st_next.bclk = ~st_reg.bclk;
         st_next.div  = 1'b0;
         fall         = st_reg.bclk;
      end else begin
         st_next.div  = 1'b1;
      end
      if (fall) begin
         if (st_reg.tx_on) begin
            st_next.line0 = dual ? w0[st_reg.bit_idx] : 1'b0;
            st_next.line1 = w1[st_reg.bit_idx];
            st_next.bit_idx = st_reg.bit_idx + 4'h1;
            if (st_reg.bit_idx == `SPF_LAST_BIT) begin
               st_next.slot = st_reg.slot + 12'h001;
               if (st_reg.slot == last_slot) begin
                  st_next.tx_on = 1'b0;
               end
            end
         end else begin
            st_next.line0 = 1'b0;
            st_next.line1 = 1'b0;
         end
         if (st_reg.tx_on && st_reg.slot == 12'h000 &&
             st_reg.bit_idx == 4'h0) begin
            st_next.marker   = 1'b1;
            st_next.mark_cnt = (fast ? `SPF_MARK_FAST : `SPF_MARK_SLOW)
                               - 4'h1;
         end else if (st_reg.mark_cnt != 4'h0) begin
            st_next.marker   = 1'b1;
            st_next.mark_cnt = st_reg.mark_cnt - 4'h1;
         end else begin
            st_next.marker   = 1'b0;
         end
      end

      // Frame sequencing
      bound = st_reg.running && (st_reg.timer == FRAME_LAST);
      st_next.start_q = LINK.start;
      if (LINK.start && !st_reg.start_q) begin
         st_next.running = 1'b1;
         st_next.timer   = 16'h0000;
         st_next.acq_cnt = 12'h000;
      end else if (bound) begin
         st_next.timer     = 16'h0000;
         st_next.acq_bank  = ~st_reg.acq_bank;
         st_next.tx_cnt    = st_reg.acq_cnt + {11'h000, wr};
         st_next.acq_cnt   = 12'h000;
         st_next.cnt_snap  = st_reg.frame_cnt;
         st_next.frame_cnt = st_reg.frame_cnt + 32'h00000001;
         st_next.tx_on     = 1'b1;
         st_next.slot      = 12'h000;
         st_next.bit_idx   = 4'h0;
      end else if (st_reg.running) begin
         st_next.timer = st_reg.timer + 16'h0001;
      end
      // Held at zero while the restart bit is set
      if (st_reg.mode[`SPF_RESTART_BIT]) begin
         st_next.frame_cnt = 32'h00000000;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (wr) begin
         mem[{st_reg.acq_bank, st_reg.acq_cnt}] <= HIT_WORD;
      end
   end

   assign LINK.bit_clk          = st_reg.bclk;
   assign LINK.serial_line_zero = st_reg.line0;
   assign LINK.serial_line_one  = st_reg.line1;
   assign LINK.marker           = st_reg.marker;
   assign BIAS_CODES            = st_reg.bias;
   assign CLAMP_CODE            = st_reg.clamp;
   assign ANA_TEST_EN           = st_reg.mode[`SPF_ANATST_BIT];
endmodule : spf_dev

//--- src/spf_ctl.sv
`timescale 1ns/1ps
`include "spf_consts.svh"
module spf_ctl (
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RESET_N,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Link to the device
   spf_link_if.ctl          LINK
);
   spf_pkg::spf_ctl_state_type st_reg;
   spf_pkg::spf_ctl_state_type st_next;

   logic        acc;
   logic        rise;
   logic        first;
   logic        dual;
   logic [15:0] f0;
   logic [15:0] f1;
   logic [2:0]  wd;
   logic [3:0]  bi;

   always_comb begin
      st_next = st_reg;
      // APB: one wait state, write applied as the access completes
      st_next.pready  = 1'b0;
      st_next.pslverr = 1'b0;
      acc = PSEL && PENABLE && st_reg.pready;
      if (PSEL && PENABLE && !st_reg.pready) begin
         st_next.pready = 1'b1;
         st_next.prdata = 32'h00000000;
         case (PADDR)
            `SPF_A_CTRL:    st_next.prdata = {29'h0, st_reg.outcfg,
                                              st_reg.start};
            `SPF_A_CFG:     st_next.prdata = {11'h0, st_reg.cfg_addr,
                                              st_reg.cfg_data};
            `SPF_A_RESTART: ;
            `SPF_A_STATUS:  st_next.prdata = {30'h0, st_reg.rx_on,
                                   st_reg.cst != spf_pkg::C_IDLE};
            `SPF_A_HDR:     st_next.prdata = st_reg.hdr;
            `SPF_A_CNT:     st_next.prdata = st_reg.cnt;
            `SPF_A_LEN:     st_next.prdata = st_reg.len;
            `SPF_A_FRAMES:  st_next.prdata = st_reg.frames;
            default:        st_next.pslverr = 1'b1;
         endcase
      end

      // Configuration engine
      st_next.cfg_we = 1'b0;
      case (st_reg.cst)
         spf_pkg::C_IDLE: begin
            if (acc && PWRITE && PADDR == `SPF_A_CFG) begin
               st_next.cfg_we   = 1'b1;
               st_next.cfg_addr = PWDATA[20:16];
               st_next.cfg_data = PWDATA[15:0];
               if (PWDATA[20:16] == `SPF_CA_MODE) begin
                  st_next.mode = PWDATA[7:0];
               end
               if (PWDATA[20:16] == `SPF_CA_OUTCFG) begin
                  st_next.outcfg = PWDATA[1:0];
               end
            end else if (acc && PWRITE && PADDR == `SPF_A_RESTART &&
                         PWDATA[0]) begin
               st_next.cst = spf_pkg::C_SET;
            end
         end
         spf_pkg::C_SET: begin
            st_next.cfg_we   = 1'b1;
            st_next.cfg_addr = `SPF_CA_MODE;
            st_next.cfg_data = {8'h00, st_reg.mode};
            st_next.cfg_data[`SPF_RESTART_BIT] = 1'b1;
            st_next.cst      = spf_pkg::C_CLR;
         end
         spf_pkg::C_CLR: begin
            st_next.cfg_we   = 1'b1;
            st_next.cfg_addr = `SPF_CA_MODE;
            st_next.cfg_data = {8'h00, st_reg.mode};
            st_next.cfg_data[`SPF_RESTART_BIT] = 1'b0;
            st_next.mode[`SPF_RESTART_BIT] = 1'b0;
            st_next.cst      = spf_pkg::C_IDLE;
         end
         default: st_next.cst = spf_pkg::C_IDLE;
      endcase
      if (acc && PWRITE && PADDR == `SPF_A_CTRL) begin
         st_next.start = PWDATA[0];
      end

      // Link receiver, sampled through two flip-flops
      st_next.s1 = {LINK.marker, LINK.serial_line_one,
                    LINK.serial_line_zero, LINK.bit_clk};
      st_next.s2 = st_reg.s1;
      st_next.clk_q = st_reg.s2[0];
      rise  = st_reg.s2[0] && !st_reg.clk_q;
      first = st_reg.s2[3] && !st_reg.mk_q;
      dual  = st_reg.outcfg[`SPF_OC_DUAL];
      wd    = first ? 3'h0 : st_reg.word;
      bi    = first ? 4'h0 : st_reg.bit_idx;
      f0    = {st_reg.s2[1], st_reg.sr0[15:1]};
      f1    = {st_reg.s2[2], st_reg.sr1[15:1]};
      if (rise) begin
         st_next.mk_q = st_reg.s2[3];
         if (st_reg.rx_on || first) begin
            st_next.rx_on   = 1'b1;
            st_next.sr0     = f0;
            st_next.sr1     = f1;
            st_next.bit_idx = bi + 4'h1;
            st_next.word    = wd;
            if (bi == `SPF_LAST_BIT) begin
               st_next.word = wd + 3'h1;
               if (dual) begin
                  case (wd)
                     3'h0: st_next.hdr = {f1, f0};
                     3'h1: st_next.cnt = {f1, f0};
                     default: begin
                        st_next.len    = {16'h0, f0} + {16'h0, f1};
                        st_next.frames = st_reg.frames + 32'h00000001;
                        st_next.rx_on  = 1'b0;
                     end
                  endcase
               end else begin
                  case (wd)
                     3'h0: st_next.hdr[15:0]  = f1;
                     3'h1: st_next.hdr[31:16] = f1;
                     3'h2: st_next.cnt[15:0]  = f1;
                     3'h3: st_next.cnt[31:16] = f1;
                     3'h4: st_next.len0       = f1;
                     default: begin
                        st_next.len    = {16'h0, st_reg.len0} +
                                         {16'h0, f1};
                        st_next.frames = st_reg.frames + 32'h00000001;
                        st_next.rx_on  = 1'b0;
                     end
                  endcase
               end
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign PRDATA        = st_reg.prdata;
   assign PREADY        = st_reg.pready;
   assign PSLVERR       = st_reg.pslverr;
   assign LINK.cfg_we   = st_reg.cfg_we;
   assign LINK.cfg_addr = st_reg.cfg_addr;
   assign LINK.cfg_data = st_reg.cfg_data;
   assign LINK.start    = st_reg.start;
endmodule : spf_ctl

//--- tb/spf_link_assertions.sv
`timescale 1ns/1ps
`include "spf_consts.svh"
module spf_link_assertions (
   // Clock and reset
   input wire logic        CLK_SYS,
   input wire logic        RESET_N,
   // Link signals
   input wire logic        cfg_we,
   input wire logic [4:0]  cfg_addr,
   input wire logic [15:0] cfg_data,
   input wire logic        start,
   input wire logic        bit_clk,
   input wire logic        serial_line_zero,
   input wire logic        serial_line_one,
   input wire logic        marker
);
   logic        dual_reg;
   logic        rate_reg;
   logic [15:0] hdr0_reg;
   logic [15:0] hdr1_reg;

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);

   // Shadow of the settings held by the device
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         dual_reg <= 1'b0;
         rate_reg <= 1'b0;
         hdr0_reg <= 16'h0000;
         hdr1_reg <= 16'h0000;
      end else if (cfg_we) begin
         if (cfg_addr == `SPF_CA_OUTCFG) begin
            dual_reg <= cfg_data[`SPF_OC_DUAL];
            rate_reg <= cfg_data[`SPF_OC_RATE];
         end
         if (cfg_addr == `SPF_CA_HDR0)
            hdr0_reg <= cfg_data;
         if (cfg_addr == `SPF_CA_HDR1)
            hdr1_reg <= cfg_data;
      end
   end

   sequence s_set;
      cfg_we && cfg_addr == `SPF_CA_MODE && cfg_data[`SPF_RESTART_BIT];
   endsequence
   sequence s_clr;
      cfg_we && cfg_addr == `SPF_CA_MODE && !cfg_data[`SPF_RESTART_BIT];
   endsequence
   sequence s_hold16;
      marker [*8] ##1 marker [*8] ##1 !marker;
   endsequence

   property p_clk_runs;
      1'b1 |-> ##[1:4] $changed(bit_clk);
   endproperty
   property p_fast_period;
      rate_reg && $past(rate_reg, 4) && $rose(bit_clk) |-> ##2 $rose(bit_clk);
   endproperty
   property p_slow_period;
      !rate_reg && !$past(rate_reg, 4) && $rose(bit_clk)
         |-> ##4 $rose(bit_clk);
   endproperty
   property p_data_on_fall;
      $changed(serial_line_zero) || $changed(serial_line_one)
         |-> $fell(bit_clk);
   endproperty
   property p_mark_on_fall;
      $changed(marker) |-> $fell(bit_clk);
   endproperty
   property p_mark_len;
      $rose(marker) |-> s_hold16;
   endproperty
   property p_mark_align;
      $rose(marker) |-> (dual_reg ? (serial_line_zero == hdr0_reg[0] &&
         serial_line_one == hdr1_reg[0]) : serial_line_one == hdr0_reg[0]);
   endproperty
   property p_single_idle;
      $rose(marker) && !dual_reg |-> !serial_line_zero [*8];
   endproperty
   property p_restart;
      s_set |=> s_clr;
   endproperty
   property p_after_start;
      $rose(marker) |-> start;
   endproperty

   a_clk_runs: assert property (p_clk_runs)
      else $error("bit clock stopped");
   a_fast_period: assert property (p_fast_period)
      else $error("fast bit clock period wrong");
   a_slow_period: assert property (p_slow_period)
      else $error("slow bit clock period wrong");
   a_data_on_fall: assert property (p_data_on_fall)
      else $error("data changed off the clock fall");
   a_mark_on_fall: assert property (p_mark_on_fall)
      else $error("marker changed off the clock fall");
   a_mark_len: assert property (p_mark_len)
      else $error("marker width wrong");
   a_mark_align: assert property (p_mark_align)
      else $error("marker not aligned with header bit 0");
   a_single_idle: assert property (p_single_idle)
      else $error("line zero active in single mode");
   a_restart: assert property (p_restart)
      else $error("restart bit not cleared next cycle");
   a_after_start: assert property (p_after_start)
      else $error("frame sent before start");
endmodule : spf_link_assertions

//--- tb/spf_bench.sv
`timescale 1ns/1ps
`include "spf_consts.svh"
module sparse_pixel_frame_serializer_bench;
   localparam int FRAME = 1200;
   logic         clk_sys;
   logic         reset_n;
   logic         psel;
   logic         penable;
   logic         pwrite;
   logic [7:0]   paddr;
   logic [31:0]  pwdata;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic         hit_valid;
   logic [15:0]  hit_word;
   logic [143:0] bias_codes;
   logic [3:0]   clamp_code;
   logic         ana_test_en;
   logic [31:0]  rdata;
   logic         rerr;
   logic [31:0]  frames;
   int           errors;
   int           checks_done;

   spf_link_if spf_link_if_inst ();
   spf_dev #(.FRAME_CYCLES(FRAME)) spf_dev_inst (
      .CLK_SYS(clk_sys), .RESET_N(reset_n), .LINK(spf_link_if_inst),
      .HIT_VALID(hit_valid), .HIT_WORD(hit_word), .BIAS_CODES(bias_codes),
      .CLAMP_CODE(clamp_code), .ANA_TEST_EN(ana_test_en));
   spf_ctl spf_ctl_inst (
      .CLK_SYS(clk_sys), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .LINK(spf_link_if_inst));
   spf_link_assertions spf_link_assertions_inst (
      .CLK_SYS(clk_sys), .RESET_N(reset_n),
      .cfg_we(spf_link_if_inst.cfg_we),
      .cfg_addr(spf_link_if_inst.cfg_addr),
      .cfg_data(spf_link_if_inst.cfg_data),
      .start(spf_link_if_inst.start),
      .bit_clk(spf_link_if_inst.bit_clk),
      .serial_line_zero(spf_link_if_inst.serial_line_zero),
      .serial_line_one(spf_link_if_inst.serial_line_one),
      .marker(spf_link_if_inst.marker));

   always #12.5 clk_sys = ~clk_sys;

   task automatic print_verdict();
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdata = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         print_verdict();
      end
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdata, exp);
   endtask : rd

   // Config write, then let the device register it
   task automatic cfg(input logic [4:0] a, input logic [15:0] d);
      apb(1'b1, `SPF_A_CFG, {11'h000, a, d});
      repeat (3) @(posedge clk_sys);
   endtask : cfg

   task automatic hits(input int k);
      repeat (k) begin
         @(posedge clk_sys);
         hit_valid <= 1'b1;
         hit_word  <= hit_word + 16'h0101;
      end
      @(posedge clk_sys);
      hit_valid <= 1'b0;
   endtask : hits

   // Poll the receiver until one more frame is decoded
   task automatic wait_frame();
      int n;
      n = 0;
      do begin
         apb(1'b0, `SPF_A_FRAMES, 32'h0);
         n++;
      end while (rdata === frames && n < 2000);
      if (rdata === frames) begin
         errors++;
         print_verdict();
      end
      frames = rdata;
   endtask : wait_frame

   initial begin
      clk_sys = 1'b0;
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      hit_valid = 1'b0;
      hit_word = 16'h0000;
      frames = 32'h0;
      errors = 0;
      checks_done = 0;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(`SPF_A_STATUS, 32'h0);
      check(bias_codes[31:0], 32'h0);
      check(ana_test_en, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      check(rdata, 32'h0);
      check(rerr, 32'h1);
      for (int i = 0; i < 18; i++) begin
         cfg(i[4:0], 16'(i * 9 + 3));
      end
      cfg(`SPF_CA_CLAMP, 16'h000a);
      for (int i = 0; i < 18; i++) begin
         check(bias_codes[8*i +: 8], 32'(i * 9 + 3));
      end
      check(clamp_code, 32'ha);
      cfg(`SPF_CA_MODE, 16'h0040);
      check(ana_test_en, 32'h1);
      cfg(`SPF_CA_MODE, 16'h0000);
      check(ana_test_en, 32'h0);
      cfg(`SPF_CA_HDR0, 16'h5a3d);
      cfg(`SPF_CA_HDR1, 16'hc3a4);
      cfg(`SPF_CA_TRL0, 16'h0ff0);
      cfg(`SPF_CA_TRL1, 16'hf00f);
      cfg(`SPF_CA_OUTCFG, 16'h0000);
      apb(1'b1, `SPF_A_CTRL, 32'h1);
      hits(5);
      wait_frame();
      rd(`SPF_A_HDR, 32'hc3a4_5a3d);
      rd(`SPF_A_LEN, 32'h6);
      rd(`SPF_A_CNT, 32'h0);
      wait_frame();
      rd(`SPF_A_LEN, 32'h0);
      rd(`SPF_A_CNT, 32'h1);
      apb(1'b1, `SPF_A_RESTART, 32'h1);
      wait_frame();
      rd(`SPF_A_CNT, 32'h0);
      // Change mode only after the frame in flight has ended
      for (int m = 1; m < 4; m++) begin
         repeat (500) @(posedge clk_sys);
         cfg(`SPF_CA_OUTCFG, 16'(m));
         hits(m + 2);
         wait_frame();
         rd(`SPF_A_LEN, 32'(2 * ((m + 3) / 2)));
         rd(`SPF_A_CNT, 32'(m));
         rd(`SPF_A_HDR, 32'hc3a4_5a3d);
         rd(`SPF_A_CTRL, {29'h0, m[1:0], 1'b1});
      end
      print_verdict();
   end
endmodule : sparse_pixel_frame_serializer_bench
